/* File: rtl/led_scan_pkg.sv */
// shared constants for the led matrix refresh scanner
package led_scan_pkg;

  // matrix geometry
  localparam int NUM_COLS       = 20;
  localparam int NUM_ROWS       = 8;
  localparam int NUM_DOTS       = NUM_COLS * NUM_ROWS;
  localparam int ROW_W          = 3;
  localparam int CNT_W          = 9;
  localparam int SLOT_W         = 6;

  // refresh timing in oscillator cycles
  localparam logic [CNT_W-1:0]  FRAME_LAST   = 9'h1ff;  // 512 cycles per refresh
  localparam logic [SLOT_W-1:0] SLOT_LAST    = 6'h3f;   // 64 cycles per row
  localparam logic [SLOT_W-1:0] BLANK_START  = 6'h3c;   // last 4 cycles blanked
  localparam logic [SLOT_W-1:0] MAX_ON       = 6'h3c;   // 60 lit cycles at most

  // oscillator source timing
  localparam int CLK_HZ         = 40_000_000;
  localparam int INT_OSC_HZ     = 320_000;
  localparam int INT_DIV_CYCLES = CLK_HZ / INT_OSC_HZ;
  localparam int DIV_W          = 8;
  localparam logic [DIV_W-1:0] INT_DIV_LAST = DIV_W'(INT_DIV_CYCLES - 1);
  localparam logic [2:0]       PRESCALE_LAST = 3'h7;    // prescaler divides by 8

  // apb register byte offsets
  localparam logic [7:0] CTRL0_OFS  = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] DOT_OFS    = 8'h20;  // rows 0..7 at 0x20..0x3c

  // reset values
  localparam logic [6:0] CTRL0_RESET  = 7'h4d;  // peak 73 percent, duty 60 percent
  localparam logic [1:0] CONFIG_RESET = 2'h0;   // internal oscillator, no prescaler

  // control word 0 field positions
  localparam int PEAK_HI = 5;
  localparam int PEAK_LO = 4;
  localparam int DUTY_HI = 3;
  localparam int DUTY_LO = 0;

  // config field positions
  localparam int CFG_EXT_OSC  = 0;
  localparam int CFG_PRESCALE = 1;

  // lit cycles per row slot for each duty code; code 4'hd gives 36 of 60
  localparam logic [SLOT_W-1:0] DUTY_ON [16] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h09,
    6'h0b, 6'h0e, 6'h12, 6'h17, 6'h1d, 6'h24, 6'h2f, 6'h3c};

  // peak current in percent of full scale per peak code
  localparam logic [6:0] PEAK_PCT [4] = '{7'h49, 7'h32, 7'h64, 7'h5d};

endpackage : led_scan_pkg

/* File: rtl/pin_sync.sv */
// three-flop pin synchroniser with debounced rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin side
  input  wire logic pin_in,
  // core side
  output logic      rise_pulse
);

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;
  logic agree;

  // a change only counts once the second and third stages agree
  assign agree = (sync2_reg == sync3_reg);

  // chain; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // accepted level and its rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg  <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      rise_pulse <= agree && sync3_reg && !level_reg;
      if (agree) level_reg <= sync3_reg;
    end
  end

endmodule : pin_sync
`default_nettype wire

/* File: rtl/led_matrix_refresh_scanner.sv */
// led matrix refresh scanner with apb register slave
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module led_matrix_refresh_scanner
  import led_scan_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // external oscillator pin
  input  wire logic        ext_osc_in,
  // led drivers
  output logic [19:0]      col_drive,
  output logic [7:0]       row_sink,
  output logic [1:0]       peak_level,
  output logic [6:0]       peak_pct,
  output logic [6:0]       bright_pct,
  output logic             frame_start
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_reg;
  logic rst_n_reg;

  // async assert, two-flop release
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [NUM_COLS-1:0] dot_reg [NUM_ROWS];
  logic [6:0]          ctrl0_reg;
  logic [1:0]          config_reg;
  logic [CNT_W-1:0]    scan_cnt_reg;
  logic [7:0]          frame_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic       acc;
  logic       wr_en;
  logic       hit_ctrl0;
  logic       hit_config;
  logic       hit_status;
  logic       hit_dot;
  logic       hit_any;
  logic [2:0] dot_idx;

  // one wait state so read data can come from a flop
  assign acc        = psel && penable && pready;
  assign wr_en      = acc && pwrite && hit_any;
  assign hit_ctrl0  = (paddr == CTRL0_OFS);
  assign hit_config = (paddr == CONFIG_OFS);
  assign hit_status = (paddr == STATUS_OFS);
  assign hit_dot    = (paddr[7:5] == DOT_OFS[7:5]) && (paddr[1:0] == 2'h0);
  assign hit_any    = hit_ctrl0 || hit_config || hit_status || hit_dot;
  assign dot_idx    = paddr[4:2];

  logic [31:0] rd_mux;

  // read selection; status shows scan position and frame count
  assign rd_mux = hit_ctrl0  ? {25'h0, ctrl0_reg} :
                  hit_config ? {30'h0, config_reg} :
                  hit_status ? {15'h0, frame_cnt_reg, scan_cnt_reg} :
                  hit_dot    ? {12'h0, dot_reg[dot_idx]} : 32'h0;

  // handshake: pready high in the second access cycle only
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= rd_mux;
      pslverr <= psel && penable && !pready && !hit_any;
    end
  end

  // control writes; status is read only
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl0_reg  <= CTRL0_RESET;
      config_reg <= CONFIG_RESET;
    end else if (wr_en) begin
      if (hit_ctrl0) ctrl0_reg <= pwdata[6:0];
      if (hit_config) config_reg <= pwdata[1:0];
    end
  end

  // dot store, one 20-bit row per word
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      for (int r = 0; r < NUM_ROWS; r++) dot_reg[r] <= '0;
    end else if (wr_en && hit_dot) begin
      dot_reg[dot_idx] <= pwdata[NUM_COLS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator source

  logic             ext_rise;
  logic [DIV_W-1:0] int_div_reg;
  logic             int_tick_reg;
  logic             src_tick;
  logic [2:0]       pre_cnt_reg;
  logic             osc_tick;

  pin_sync u_ext_sync (
    .clk        (core_clk),
    .rst_n      (rst_n_reg),
    .pin_in     (ext_osc_in),
    .rise_pulse (ext_rise)
  );

  // internal oscillator as a divided enable pulse
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      int_div_reg  <= '0;
      int_tick_reg <= 1'b0;
    end else begin
      int_tick_reg <= (int_div_reg == INT_DIV_LAST);
      int_div_reg  <= (int_div_reg == INT_DIV_LAST) ? '0 : int_div_reg + 1'b1;
    end
  end

  // source select; the external pin must stay slow against core_clk
  assign src_tick = config_reg[CFG_EXT_OSC] ? ext_rise : int_tick_reg;

  // optional divide by 8, meant for fast external clocks
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pre_cnt_reg <= '0;
    end else if (src_tick) begin
      pre_cnt_reg <= pre_cnt_reg + 1'b1;
    end
  end

  assign osc_tick = src_tick &&
                    (!config_reg[CFG_PRESCALE] || pre_cnt_reg == PRESCALE_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // refresh counters

  logic [ROW_W-1:0]  row_sel;
  logic [SLOT_W-1:0] slot_cnt;
  logic [3:0]        duty_code;
  logic [1:0]        peak_code;
  logic [SLOT_W-1:0] on_cycles;
  logic              blank;
  logic              pwm_on;
  logic              lit;

  // row in upper bits, slot position in lower six
  assign row_sel   = scan_cnt_reg[CNT_W-1:SLOT_W];
  assign slot_cnt  = scan_cnt_reg[SLOT_W-1:0];
  assign duty_code = ctrl0_reg[DUTY_HI:DUTY_LO];
  assign peak_code = ctrl0_reg[PEAK_HI:PEAK_LO];
  assign on_cycles = DUTY_ON[duty_code];
  assign blank     = (slot_cnt >= BLANK_START);
  assign pwm_on    = (slot_cnt < on_cycles);
  assign lit       = !blank && pwm_on;

  // one count per oscillator tick, wrapping after 512
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      scan_cnt_reg  <= '0;
      frame_cnt_reg <= '0;
    end else if (osc_tick) begin
      scan_cnt_reg <= (scan_cnt_reg == FRAME_LAST) ? '0 : scan_cnt_reg + 1'b1;
      if (scan_cnt_reg == FRAME_LAST) frame_cnt_reg <= frame_cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // driver outputs

  logic [13:0] bright_prod;

  // product kept in integer percent; truncation loses under one percent
  assign bright_prod = 14'(PEAK_PCT[peak_code]) * 14'(on_cycles);

  // all driver outputs registered; row sink and columns dark while blanked
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      col_drive   <= '0;
      row_sink    <= '0;
      peak_level  <= '0;
      peak_pct    <= '0;
      bright_pct  <= '0;
      frame_start <= 1'b0;
    end else begin
      col_drive   <= lit ? dot_reg[row_sel] : '0;
      row_sink    <= blank ? 8'h00 : 8'(8'h01 << row_sel);
      peak_level  <= peak_code;
      peak_pct    <= PEAK_PCT[peak_code];
      bright_pct  <= 7'(bright_prod / 14'(MAX_ON));
      frame_start <= osc_tick && (scan_cnt_reg == FRAME_LAST);
    end
  end

endmodule : led_matrix_refresh_scanner
`default_nettype wire

/* File: testbench/scan_monitor.sv */
// port checker for the led matrix refresh scanner
`timescale 1ns/1ps
`default_nettype none
module scan_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // drivers
  input wire logic [19:0] col_drive,
  input wire logic [7:0]  row_sink,
  input wire logic [6:0]  peak_pct,
  input wire logic [6:0]  bright_pct,
  input wire logic        frame_start
);
  logic [7:0] last_row;
  // last lit row, so the row after a blank can be checked
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) last_row <= 8'h00;
    else if (row_sink != 8'h00) last_row <= row_sink;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_onehot; $onehot0(row_sink); endproperty
  a_onehot: assert property (p_onehot) else $error("row sinks not one-hot");
  property p_row_next;
    $past(row_sink) == 8'h00 && row_sink != 8'h00 && last_row != 8'h00
      |-> row_sink == {last_row[6:0], last_row[7]};
  endproperty
  a_row_next: assert property (p_row_next) else $error("row out of order");
  property p_col_blank; row_sink == 8'h00 |-> col_drive == 20'h00000; endproperty
  a_col_blank: assert property (p_col_blank) else $error("column lit in blank");
  property p_frame; frame_start |-> (row_sink & 8'hfe) == 8'h00 ##1 !frame_start; endproperty
  a_frame: assert property (p_frame) else $error("bad frame pulse");
  property p_ready_time; psel && !penable |-> ##2 pready; endproperty
  a_ready_time: assert property (p_ready_time) else $error("apb answer late");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready too long");
  property p_slverr; pslverr |-> pready && psel && penable; endproperty
  a_slverr: assert property (p_slverr) else $error("stray slave error");
  property p_bright; $stable(peak_pct) [*2] |-> bright_pct <= peak_pct; endproperty
  a_bright: assert property (p_bright) else $error("brightness above peak");
endmodule : scan_monitor
bind led_matrix_refresh_scanner scan_monitor mon (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .col_drive(col_drive), .row_sink(row_sink), .peak_pct(peak_pct),
  .bright_pct(bright_pct), .frame_start(frame_start));
`default_nettype wire

/* File: testbench/led_load_model.sv */
// led sink and source load, totals lit time per refresh
`timescale 1ns/1ps
`default_nettype none
module led_load_model (
  // drive side
  input wire logic         core_clk,
  input wire logic [19:0]  col_drive,
  input wire logic [7:0]   row_sink,
  input wire logic         frame_start,
  // totals of the refresh ending at the last frame pulse, and last lit columns seen per row
  output var logic [15:0]  frame_len,
  output var logic [15:0]  row_on,
  output var logic [15:0]  col_on,
  output var logic [19:0]  seen [8]
);
  logic [15:0] cnt = 16'h0;
  logic [15:0] rl  = 16'h0;
  logic [15:0] cl  = 16'h0;
  // counts restart on each frame pulse; a partial first frame is latched like any other at the first pulse
  always @(posedge core_clk) begin
    cnt <= frame_start ? 16'h1 : cnt + 16'h1;
    rl <= (frame_start ? 16'h0 : rl) + 16'(row_sink != 8'h00);
    cl <= (frame_start ? 16'h0 : cl) + 16'(col_drive != 20'h0);
    if (frame_start) begin
      frame_len <= cnt;
      row_on <= rl;
      col_on <= cl;
    end
    for (int i = 0; i < 8; i++) if (row_sink[i] && col_drive != 20'h0) seen[i] <= col_drive;
  end
endmodule : led_load_model
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the led matrix refresh scanner
`timescale 1ns/1ps
`default_nettype none
module tb;
  import led_scan_pkg::*;
  localparam int OSC_HALF = 20;  // 1 MHz pin clock, inside both limits
  logic        core_clk = 1'b0, reset_n = 1'b0, ext_osc_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic        e, pready, pslverr, frame_start;
  logic [19:0] col_drive, seen [8];
  logic [7:0]  row_sink;
  logic [1:0]  peak_level;
  logic [6:0]  peak_pct, bright_pct;
  logic [15:0] frame_len, row_on, col_on;
  int          bad_count = 0, cmp_count = 0, cycles = 0, oc = 0, on, pk;
  led_matrix_refresh_scanner dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_osc_in(ext_osc_in), .col_drive(col_drive),
    .row_sink(row_sink), .peak_level(peak_level), .peak_pct(peak_pct),
    .bright_pct(bright_pct), .frame_start(frame_start));
  led_load_model load (.core_clk(core_clk), .col_drive(col_drive), .row_sink(row_sink),
    .frame_start(frame_start), .frame_len(frame_len), .row_on(row_on), .col_on(col_on),
    .seen(seen));
  always #12.5 core_clk = ~core_clk;
  // free-running pin oscillator and hang guard
  always @(posedge core_clk) begin
    cycles++;
    oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
    if (oc == OSC_HALF - 1) ext_osc_in <= ~ext_osc_in;
    if (cycles >= 100000) begin
      bad_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] pat(input int r);
    return 20'h0a5c3 + 20'(r) * 20'h11111;
  endfunction : pat
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // one apb transfer; pready, prdata and pslverr are taken at the same rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 100) bad_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task fwait;
    int n;
    n = 0;
    @(negedge core_clk);
    while (frame_start !== 1'b1 && n < 30000) begin @(negedge core_clk); n++; end
    if (n >= 30000) bad_count++;
  endtask : fwait
  // length of the next whole blank gap, in core cycles
  task blank_len(output int len);
    len = 0;
    @(negedge core_clk);
    while (row_sink == 8'h00) @(negedge core_clk);
    while (row_sink != 8'h00) @(negedge core_clk);
    while (row_sink == 8'h00) begin
      @(negedge core_clk);
      len++;
    end
  endtask : blank_len
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b0, CTRL0_OFS, 32'h0); chk("ctrl0", q, 32'h4d);
    apb(1'b0, CONFIG_OFS, 32'h0); chk("config", q, 32'h0);
    apb(1'b0, 8'h10, 32'h0); chk("unmapped", {q[30:0], e}, 32'h1);
    $display("test registers done");
    blank_len(on);
    chk("internal blank", 32'(on), 32'(4 * INT_DIV_CYCLES));
    $display("test internal oscillator done");
    for (int r = 0; r < 8; r++) apb(1'b1, DOT_OFS + 8'(4 * r), 32'(pat(r)));
    for (int r = 0; r < 8; r++) begin
      apb(1'b0, DOT_OFS + 8'(4 * r), 32'h0); chk("dot row", q, 32'(pat(r)));
    end
    $display("test dot store done");
    for (int p = 3; p >= 0; p--) begin
      apb(1'b1, CTRL0_OFS, 32'(p * 16 + 13));
      pk = (p == 0) ? 73 : int'(PEAK_PCT[p]);
      repeat (2) @(negedge core_clk);
      chk("peak level", 32'(peak_level), 32'(p));
      chk("peak pct", 32'(peak_pct), p == 0 ? 32'd73 : 32'(PEAK_PCT[p]));
      chk("bright", 32'(bright_pct), 32'(pk * 36 / 60));
    end
    $display("test brightness done");
    apb(1'b1, CONFIG_OFS, 32'h1);
    fwait();  // first frame mixes both sources, so it is not checked
    for (int k = 0; k < 2; k++) begin
      on = k ? 60 : 36;
      if (k) apb(1'b1, CTRL0_OFS, 32'h4f);  // lands in slot 0, lit under either duty
      fwait();
      repeat (2) @(negedge core_clk);
      chk("frame", 32'(frame_len), 32'(1024 * OSC_HALF));
      chk("row lit", 32'(row_on), 32'(960 * OSC_HALF));
      chk("col lit", 32'(col_on), 32'(16 * on * OSC_HALF));
      for (int r = 0; r < 8; r++) chk("columns", 32'(seen[r]), 32'(pat(r)));
      apb(1'b0, STATUS_OFS, 32'h0); chk("status", q, 32'((k + 2) * 512));
    end
    $display("test refresh done");
    apb(1'b1, CONFIG_OFS, 32'h3);
    apb(1'b0, CONFIG_OFS, 32'h0); chk("prescale", q, 32'h3);
    blank_len(on);
    chk("prescale blank", 32'(on), 32'(4 * 8 * 2 * OSC_HALF));
    $display("test prescale done");
    conclude();
  end
endmodule : tb
`default_nettype wire
